/* File: inc/ptr_pkg.sv */
package ptr_pkg;
    localparam logic [15:0] OFS_PHASE = 16'h0502;
    localparam logic [15:0] OFS_NS_HI = 16'h0504;
    localparam logic [15:0] OFS_NS_LO = 16'h0506;
    localparam logic [15:0] OFS_SEC_HI = 16'h0508;
    localparam logic [15:0] OFS_SEC_LO = 16'h050A;
    localparam logic [15:0] OFS_RATE_HI = 16'h050C;
    localparam logic [15:0] OFS_RATE_LO = 16'h050E;
    localparam logic [15:0] OFS_DUR_HI = 16'h0510;
    localparam logic [15:0] OFS_DUR_LO = 16'h0512;
    localparam logic [15:0] OFS_CTRL = 16'h0500;
    localparam int RATE_DIR_BIT = 15;
    localparam int RATE_TEMP_BIT = 14;
    localparam int CTL_STEP_BIT = 6;
    localparam int CTL_STEP_DIR_BIT = 5;
    localparam int CTL_READ_BIT = 4;
    localparam int CTL_LOAD_BIT = 3;
    localparam int CTL_CONT_BIT = 2;
    localparam int CTL_EN_BIT = 1;
    localparam int CTL_RST_BIT = 0;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] CTRL_KEEP_MASK = 16'h0026;
    localparam logic [2:0] PHASE_LAST = 3'h4;
    localparam logic [31:0] NS_PER_TICK = 32'h0000_0028;
    localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
endpackage

/* File: logic/ptr_rtc.sv */
`timescale 1ns/1ns
module ptr_rtc
    import ptr_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    output logic TEMP_ACTIVE_OUT
);
    // shadow words seen by software
    logic [2:0] phase_ff;
    logic [31:0] ns_ff;
    logic [31:0] sec_ff;
    logic [15:0] rate_hi_ff;
    logic [15:0] rate_lo_ff;
    logic [31:0] dur_ff;
    logic [15:0] ctrl_ff;
    // running clock
    logic [2:0] rt_phase_ff;
    logic [31:0] rt_ns_ff;
    logic [31:0] rt_sec_ff;
    logic [31:0] rt_frac_ff;
    logic [31:0] temp_cnt_ff;
    logic temp_run_ff;
    logic [15:0] rdata_ff;

    logic wr_phase;
    logic wr_ns_hi;
    logic wr_ns_lo;
    logic wr_sec_hi;
    logic wr_sec_lo;
    logic wr_rate_hi;
    logic wr_rate_lo;
    logic wr_dur_hi;
    logic wr_dur_lo;
    logic wr_ctrl;
    logic cmd_read;
    logic cmd_load;
    logic cmd_step;
    logic cmd_rst;
    logic [29:0] rate;
    logic adjust;
    logic temp_done;
    logic [32:0] nxt_frac;
    logic [31:0] adj_ns;
    logic [31:0] nxt_ns;
    logic [31:0] nxt_sec;
    // step result, seconds carried or borrowed
    logic [32:0] step_sum;
    logic [31:0] step_ns;
    logic [31:0] step_sec;

    // one address compare shared by every register strobe
    function automatic logic reg_hit(input logic strobe,
        input logic [15:0] addr, input logic [15:0] ofs);
        return strobe && addr == ofs;
    endfunction

    assign wr_phase = reg_hit(WR_IN, ADDR_IN, OFS_PHASE);
    assign wr_ns_hi = reg_hit(WR_IN, ADDR_IN, OFS_NS_HI);
    assign wr_ns_lo = reg_hit(WR_IN, ADDR_IN, OFS_NS_LO);
    assign wr_sec_hi = reg_hit(WR_IN, ADDR_IN, OFS_SEC_HI);
    assign wr_sec_lo = reg_hit(WR_IN, ADDR_IN, OFS_SEC_LO);
    assign wr_rate_hi = reg_hit(WR_IN, ADDR_IN, OFS_RATE_HI);
    assign wr_rate_lo = reg_hit(WR_IN, ADDR_IN, OFS_RATE_LO);
    assign wr_dur_hi = reg_hit(WR_IN, ADDR_IN, OFS_DUR_HI);
    assign wr_dur_lo = reg_hit(WR_IN, ADDR_IN, OFS_DUR_LO);
    assign wr_ctrl = reg_hit(WR_IN, ADDR_IN, OFS_CTRL);
    assign cmd_read = wr_ctrl && WDATA_IN[CTL_READ_BIT];
    assign cmd_load = wr_ctrl && WDATA_IN[CTL_LOAD_BIT];
    assign cmd_step = wr_ctrl && WDATA_IN[CTL_STEP_BIT];
    assign cmd_rst = wr_ctrl && WDATA_IN[CTL_RST_BIT];

    assign rate = {rate_hi_ff[13:0], rate_lo_ff};
    assign adjust = ctrl_ff[CTL_CONT_BIT] || temp_run_ff;
    // last counted cycle; the counter only moves while enabled
    assign temp_done = temp_run_ff && ctrl_ff[CTL_EN_BIT]
        && temp_cnt_ff == 32'h1;

    // fraction in units of 2^-32 ns; carry or borrow moves whole ns
    always_comb
    begin
        nxt_frac = {1'b0, rt_frac_ff};
        adj_ns = NS_PER_TICK;
        if (adjust)
        begin
            if (rate_hi_ff[RATE_DIR_BIT])
            begin
                nxt_frac = {1'b0, rt_frac_ff} + {3'h0, rate};
                adj_ns = NS_PER_TICK + {31'h0, nxt_frac[32]};
            end
            else
            begin
                nxt_frac = {1'b0, rt_frac_ff} - {3'h0, rate};
                adj_ns = NS_PER_TICK - {31'h0, nxt_frac[32]};
            end
        end
    end

    // one 40 ns tick per clock; rollover at one second
    always_comb
    begin
        nxt_ns = rt_ns_ff + adj_ns;
        nxt_sec = rt_sec_ff;
        if (nxt_ns >= NS_PER_SEC)
        begin
            nxt_ns = nxt_ns - NS_PER_SEC;
            nxt_sec = rt_sec_ff + 32'h1;
        end
    end

    // step assumes the held value is below one second
    always_comb
    begin
        step_sum = {1'b0, rt_ns_ff} + {1'b0, ns_ff};
        step_ns = rt_ns_ff - ns_ff;
        step_sec = rt_sec_ff;
        if (WDATA_IN[CTL_STEP_DIR_BIT])
        begin
            step_ns = step_sum[31:0];
            if (step_sum >= {1'b0, NS_PER_SEC})
            begin
                step_ns = 32'(step_sum - {1'b0, NS_PER_SEC});
                step_sec = rt_sec_ff + 32'h1;
            end
        end
        else if (rt_ns_ff < ns_ff)
        begin
            step_ns = rt_ns_ff + NS_PER_SEC - ns_ff;
            step_sec = rt_sec_ff - 32'h1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rt_phase_ff <= 3'h0;
            rt_ns_ff <= 32'h0;
            rt_sec_ff <= 32'h0;
            rt_frac_ff <= 32'h0;
        end
        else if (cmd_rst)
        begin
            rt_phase_ff <= 3'h0;
            rt_ns_ff <= 32'h0;
            rt_sec_ff <= 32'h0;
            rt_frac_ff <= 32'h0;
        end
        else if (cmd_load)
        begin
            rt_phase_ff <= phase_ff;
            rt_ns_ff <= ns_ff;
            rt_sec_ff <= sec_ff;
            rt_frac_ff <= 32'h0;
        end
        else if (cmd_step)
        begin
            rt_ns_ff <= step_ns;
            rt_sec_ff <= step_sec;
        end
        else if (ctrl_ff[CTL_EN_BIT])
        begin
            rt_ns_ff <= nxt_ns;
            rt_sec_ff <= nxt_sec;
            rt_frac_ff <= nxt_frac[31:0];
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            phase_ff <= 3'h0;
            ns_ff <= 32'h0;
            sec_ff <= 32'h0;
        end
        else if (cmd_read)
        begin
            phase_ff <= rt_phase_ff;
            ns_ff <= rt_ns_ff;
            sec_ff <= rt_sec_ff;
        end
        else
        begin
            // codes above four are kept as written
            if (wr_phase)
                phase_ff <= WDATA_IN[2:0];
            if (wr_ns_hi)
                ns_ff[31:16] <= WDATA_IN;
            if (wr_ns_lo)
                ns_ff[15:0] <= WDATA_IN;
            if (wr_sec_hi)
                sec_ff[31:16] <= WDATA_IN;
            if (wr_sec_lo)
                sec_ff[15:0] <= WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rate_hi_ff <= RESET_WORD;
            rate_lo_ff <= RESET_WORD;
        end
        else
        begin
            if (wr_rate_hi)
                rate_hi_ff <= WDATA_IN;
            else if (temp_done)
                rate_hi_ff[RATE_TEMP_BIT] <= 1'b0;
            if (wr_rate_lo)
                rate_lo_ff <= WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            dur_ff <= 32'h0;
        else
        begin
            if (wr_dur_hi)
                dur_ff[31:16] <= WDATA_IN;
            if (wr_dur_lo)
                dur_ff[15:0] <= WDATA_IN;
        end
    end

    // command bits self clear; only level bits persist
    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            ctrl_ff <= RESET_WORD;
        else if (wr_ctrl)
            ctrl_ff <= WDATA_IN & CTRL_KEEP_MASK;
    end

    // temporary run counts duration cycles from the set of the bit
    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            temp_run_ff <= 1'b0;
            temp_cnt_ff <= 32'h0;
        end
        else if (wr_rate_hi)
        begin
            temp_run_ff <= WDATA_IN[RATE_TEMP_BIT] && dur_ff != 32'h0;
            temp_cnt_ff <= dur_ff;
        end
        else if (temp_run_ff && ctrl_ff[CTL_EN_BIT])
        begin
            temp_cnt_ff <= temp_cnt_ff - 32'h1;
            if (temp_done)
                temp_run_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            rdata_ff <= RESET_WORD;
        else if (RD_IN)
        begin
            unique case (ADDR_IN)
                OFS_PHASE: rdata_ff <= {13'h0, phase_ff};
                OFS_NS_HI: rdata_ff <= ns_ff[31:16];
                OFS_NS_LO: rdata_ff <= ns_ff[15:0];
                OFS_SEC_HI: rdata_ff <= sec_ff[31:16];
                OFS_SEC_LO: rdata_ff <= sec_ff[15:0];
                OFS_RATE_HI: rdata_ff <= rate_hi_ff;
                OFS_RATE_LO: rdata_ff <= rate_lo_ff;
                OFS_DUR_HI: rdata_ff <= dur_ff[31:16];
                OFS_DUR_LO: rdata_ff <= dur_ff[15:0];
                OFS_CTRL: rdata_ff <= ctrl_ff;
                default: rdata_ff <= RESET_WORD;
            endcase
        end
    end

    assign RDATA_OUT = rdata_ff;
    assign TEMP_ACTIVE_OUT = temp_run_ff;
endmodule

/* File: testbench/ptr_rtc_props.sv */
`timescale 1ns/1ns
module ptr_rtc_props
    import ptr_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [15:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [15:0] RDATA_OUT,
    input wire logic TEMP_ACTIVE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    chk_rdata_holds: assert property (!RD_IN |=> $stable(RDATA_OUT))
        else $error("read data moved without a read");
    chk_phase_upper_zero: assert property (
        RD_IN && ADDR_IN == OFS_PHASE |=> RDATA_OUT[15:3] == 13'h0000)
        else $error("phase upper bits not zero");
    chk_cmd_bits_zero: assert property (
        RD_IN && ADDR_IN == OFS_CTRL |=> RDATA_OUT[6] == 1'b0 &&
        RDATA_OUT[4:3] == 2'h0 && !RDATA_OUT[0])
        else $error("command bits read back set");
    chk_temp_start_cause: assert property ($rose(TEMP_ACTIVE_OUT) |->
        $past(WR_IN && ADDR_IN == OFS_RATE_HI && WDATA_IN[RATE_TEMP_BIT]))
        else $error("temporary run began without a request");
    chk_temp_stops: assert property (
        WR_IN && ADDR_IN == OFS_RATE_HI && !WDATA_IN[RATE_TEMP_BIT]
        |=> !TEMP_ACTIVE_OUT) else $error("temporary run not stopped");
    chk_ns_lo_echo: assert property (WR_IN && ADDR_IN == OFS_NS_LO ##1
        RD_IN && !WR_IN && ADDR_IN == OFS_NS_LO
        |=> RDATA_OUT == $past(WDATA_IN, 2)) else $error("ns low echo");
    chk_sec_hi_echo: assert property (WR_IN && ADDR_IN == OFS_SEC_HI ##1
        RD_IN && !WR_IN && ADDR_IN == OFS_SEC_HI
        |=> RDATA_OUT == $past(WDATA_IN, 2)) else $error("sec high echo");
    chk_rate_lo_echo: assert property (WR_IN && ADDR_IN == OFS_RATE_LO ##1
        RD_IN && !WR_IN && ADDR_IN == OFS_RATE_LO
        |=> RDATA_OUT == $past(WDATA_IN, 2)) else $error("rate low echo");
    chk_dur_hi_echo: assert property (WR_IN && ADDR_IN == OFS_DUR_HI ##1
        RD_IN && !WR_IN && ADDR_IN == OFS_DUR_HI
        |=> RDATA_OUT == $past(WDATA_IN, 2)) else $error("duration echo");
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ns
module tb
    import ptr_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, temp;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, got, a, d;
    integer failures = 0, n_checks = 0, seed = 32'h55BAF77D, i, n;
    always #25 clk = ~clk;
    ptr_rtc uut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .TEMP_ACTIVE_OUT(temp));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one access per cycle, so writes and reads can run back to back
    task automatic acc(input logic w, input logic [15:0] ad, dt);
        wr = w;
        rd = !w;
        addr = ad;
        wdata = dt;
        @(posedge clk) #5;
        got = rdata;
    endtask
    task automatic idle(input integer k);
        wr = 1'b0;
        rd = 1'b0;
        repeat (k) @(posedge clk) #5;
    endtask
    function automatic logic [15:0] in_band(input logic [15:0] v, lo, hi);
        return 16'(v > lo && v < hi);
    endfunction
    task automatic report_and_stop;
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        failures++;
        report_and_stop;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        #5 rst_n = 1'b1;
        // last index lands past the map and must read zero
        for (i = 0; i < 10; i++)
        begin
            acc(1'b0, 16'h0502 + 16'(2 * i), 16'h0000);
            chk(got, RESET_WORD);
        end
        for (i = 0; i < 40; i++)
        begin
            n = {$random(seed)} % 9;
            a = 16'h0502 + 16'(2 * n);
            d = 16'($random(seed));
            if (a == OFS_PHASE)
                d = 16'({$random(seed)} % 5);
            if (a == OFS_RATE_HI)
                d[RATE_TEMP_BIT] = 1'b0;
            acc(1'b1, a, d);
            acc(1'b0, a, 16'h0000);
            chk(got, d);
        end
        // one tick short of a second, then load with the clock stopped
        acc(1'b1, OFS_NS_HI, 16'h3B9A);
        acc(1'b1, OFS_NS_LO, 16'hC9D8);
        acc(1'b1, OFS_SEC_LO, 16'h0005);
        acc(1'b1, OFS_CTRL, 16'h0008);
        acc(1'b1, OFS_NS_LO, 16'h0000);
        acc(1'b1, OFS_CTRL, 16'h0010);
        acc(1'b0, OFS_NS_LO, 16'h0000);
        chk(got, 16'hC9D8);
        acc(1'b1, OFS_CTRL, 16'h000A);
        idle(3);
        acc(1'b1, OFS_CTRL, 16'h0012);
        acc(1'b0, OFS_SEC_LO, 16'h0000);
        chk(got, 16'h0006);
        acc(1'b0, OFS_NS_LO, 16'h0000);
        chk(in_band(got, 16'h0000, 16'h00C8), 16'h0001);
        // quarter-ns rate: only the residue below one tick is compared
        for (i = 1; i >= 0; i--)
        begin
            acc(1'b1, OFS_NS_HI, 16'h0000);
            acc(1'b1, OFS_NS_LO, 16'h0FA0);
            acc(1'b1, OFS_RATE_LO, 16'hFFFF);
            acc(1'b1, OFS_RATE_HI, {i[0], 15'h3FFF} & 16'hBFFF);
            acc(1'b1, OFS_CTRL, 16'h000E);
            idle(20);
            acc(1'b1, OFS_CTRL, 16'h0016);
            acc(1'b0, OFS_NS_LO, 16'h0000);
            d = 16'(got % 16'h0028);
            d = (i == 1) ? in_band(d, 16'h0000, 16'h0014)
                : in_band(d, 16'h0014, 16'h0028);
            chk(d, 16'h0001);
        end
        acc(1'b1, OFS_CTRL, 16'h0002);
        acc(1'b1, OFS_DUR_HI, 16'h0000);
        acc(1'b1, OFS_DUR_LO, 16'h0006);
        acc(1'b1, OFS_RATE_HI, 16'hC000);
        idle(0);
        n = 0;
        repeat (20)
        begin
            if (temp === 1'b1)
                n++;
            @(posedge clk) #5;
        end
        chk(16'(n), 16'h0006);
        acc(1'b0, OFS_RATE_HI, 16'h0000);
        chk(got, 16'h8000);
        // clock reset, then steps across a second boundary both ways
        acc(1'b1, OFS_CTRL, 16'h0001);
        acc(1'b1, OFS_CTRL, 16'h0010);
        acc(1'b0, OFS_SEC_LO, 16'h0000);
        chk(got, 16'h0000);
        acc(1'b1, OFS_SEC_LO, 16'h0005);
        acc(1'b1, OFS_NS_HI, NS_PER_SEC[31:16]);
        acc(1'b1, OFS_NS_LO, NS_PER_SEC[15:0] - 16'h0028);
        acc(1'b1, OFS_CTRL, 16'h0008);
        acc(1'b1, OFS_NS_HI, 16'h0000);
        acc(1'b1, OFS_NS_LO, 16'h0064);
        acc(1'b1, OFS_CTRL, 16'h0060);
        acc(1'b0, OFS_CTRL, 16'h0000);
        chk(got, 16'h0020);
        acc(1'b1, OFS_CTRL, 16'h0010);
        acc(1'b0, OFS_SEC_LO, 16'h0000);
        chk(got, 16'h0006);
        acc(1'b0, OFS_NS_LO, 16'h0000);
        chk(got, 16'h003C);
        acc(1'b1, OFS_NS_LO, 16'h00C8);
        acc(1'b1, OFS_CTRL, 16'h0040);
        acc(1'b1, OFS_CTRL, 16'h0010);
        acc(1'b0, OFS_NS_LO, 16'h0000);
        chk(got, NS_PER_SEC[15:0] - 16'h008C);
        acc(1'b0, OFS_SEC_LO, 16'h0000);
        chk(got, 16'h0005);
        // long temporary run cut short by clearing its bit
        acc(1'b1, OFS_DUR_HI, 16'h0001);
        acc(1'b1, OFS_RATE_HI, 16'h4000);
        idle(2);
        chk(16'(temp), 16'h0001);
        acc(1'b1, OFS_RATE_HI, 16'h0000);
        chk(16'(temp), 16'h0000);
        acc(1'b0, OFS_RATE_HI, 16'h0000);
        chk(got, 16'h0000);
        idle(1);
        report_and_stop;
    end
endmodule
bind ptr_rtc ptr_rtc_props chk_i (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .TEMP_ACTIVE_OUT(TEMP_ACTIVE_OUT));
